// ==== core/mcrb_bank.sv ====
// Misc config register bank: paged control registers, hang flag and address match.

// Notes on behaviour
// - Divider power follows bit seven.
// - Ratio field divides; zero means 128.
// - Bit six low means hang; read clears.
// - General call bit adds general call address.
// - Fixed read-only part code; writes ignored.
// - Page register, reset one, selects page.
// - Ramp field selects 384k or 352.8k.
// - Spread depth one is 5%, two 10%.
// - Protection bit two low enables retry.
module mcrb_bank #(
	// The part code value is arbitrary and names no real part.
	parameter logic [7:0] PART_CODE = 8'h5a
) (
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire mcrb_pkg::mcrb_req_t req,
	input  wire logic               hang_event,
	input  wire logic               bus_addr_valid,
	input  wire logic [6:0]         bus_addr,
	input  wire logic [6:0]         own_addr,
	output logic [7:0]              rdata,
	output logic                    rvalid,
	output logic                    addr_match,
	output logic [7:0]              page_select,
	output mcrb_pkg::mcrb_ctrl_t    ctrl
);

	mcrb_pkg::mcrb_state_t s_reg;
	mcrb_pkg::mcrb_state_t s_next;

	function automatic logic hit(input logic [7:0] page, input logic [7:0] ofs,
	                             input logic [7:0] a, input logic [7:0] cur_page);
		hit = (cur_page == page) && (a == ofs);
	endfunction

	// Hang detection arrives from the bus engine on the same clock, so no synchroniser.
	always_comb begin
		s_next        = s_reg;
		s_next.rvalid = 1'b0;
		s_next.rdata  = 8'h00;
		if (hang_event) begin
			s_next.hang_seen = 1'b1;
		end
		if (req.rd) begin
			s_next.rvalid = 1'b1;
			if (req.addr == mcrb_pkg::OFS_PAGE_SELECT) begin
				s_next.rdata = s_reg.page_sel;
			end else if (hit(mcrb_pkg::PAGE_CLK, mcrb_pkg::OFS_CLKOUT_DIV, req.addr,
			                 s_reg.page_sel)) begin
				s_next.rdata = s_reg.clkout_div;
			end else if (hit(mcrb_pkg::PAGE_CLK, mcrb_pkg::OFS_BUS_OPTIONS, req.addr,
			                 s_reg.page_sel)) begin
				s_next.rdata = s_reg.bus_opts;
				s_next.rdata[mcrb_pkg::BIT_HANG] = ~s_reg.hang_seen;
				// A new hang in the same cycle as the read survives: set wins.
				if (!hang_event) begin
					s_next.hang_seen = 1'b0;
				end
			end else if (hit(mcrb_pkg::PAGE_CLK, mcrb_pkg::OFS_PART_ID, req.addr,
			                 s_reg.page_sel)) begin
				s_next.rdata = PART_CODE;
			end else if (hit(mcrb_pkg::PAGE_AMP, mcrb_pkg::OFS_RAMP_CTRL, req.addr,
			                 s_reg.page_sel)) begin
				s_next.rdata = s_reg.ramp_ctrl;
			end else if (hit(mcrb_pkg::PAGE_AMP, mcrb_pkg::OFS_PROTECTION, req.addr,
			                 s_reg.page_sel)) begin
				s_next.rdata = s_reg.protection;
			end
		end else if (req.wr) begin
			if (req.addr == mcrb_pkg::OFS_PAGE_SELECT) begin
				s_next.page_sel = req.wdata;
			end else if (hit(mcrb_pkg::PAGE_CLK, mcrb_pkg::OFS_CLKOUT_DIV, req.addr,
			                 s_reg.page_sel)) begin
				s_next.clkout_div = req.wdata;
			end else if (hit(mcrb_pkg::PAGE_CLK, mcrb_pkg::OFS_BUS_OPTIONS, req.addr,
			                 s_reg.page_sel)) begin
				// The hang bit is status only; its written value is dropped.
				s_next.bus_opts = req.wdata & ~(8'h01 << mcrb_pkg::BIT_HANG);
			end else if (hit(mcrb_pkg::PAGE_AMP, mcrb_pkg::OFS_RAMP_CTRL, req.addr,
			                 s_reg.page_sel)) begin
				s_next.ramp_ctrl = req.wdata;
			end else if (hit(mcrb_pkg::PAGE_AMP, mcrb_pkg::OFS_PROTECTION, req.addr,
			                 s_reg.page_sel)) begin
				s_next.protection = req.wdata;
			end
		end
		s_next.addr_match = bus_addr_valid && ((bus_addr == own_addr) ||
			(s_reg.bus_opts[mcrb_pkg::BIT_GCALL] &&
			 bus_addr == mcrb_pkg::GCALL_ADDR));
		s_next.ctrl.clkout_divider_power =
			s_next.clkout_div[mcrb_pkg::BIT_DIV_POWER];
		s_next.ctrl.clkout_divide_by = (s_next.clkout_div[6:0] == 7'h00) ?
			mcrb_pkg::DIV_RATIO_ZERO : {1'b0, s_next.clkout_div[6:0]};
		s_next.ctrl.general_call_accept = s_next.bus_opts[mcrb_pkg::BIT_GCALL];
		s_next.ctrl.ramp_freq_sel =
			s_next.ramp_ctrl[mcrb_pkg::POS_RAMP_FREQ +: 2];
		s_next.ctrl.ramp_cfg_valid =
			(s_next.ctrl.ramp_freq_sel == mcrb_pkg::RAMP_384K) ||
			(s_next.ctrl.ramp_freq_sel == mcrb_pkg::RAMP_352K8);
		s_next.ctrl.sawtooth_spread_depth =
			s_next.ramp_ctrl[mcrb_pkg::POS_SPREAD +: 2];
		s_next.ctrl.spread_cfg_valid =
			(s_next.ctrl.sawtooth_spread_depth == mcrb_pkg::SPREAD_5PCT) ||
			(s_next.ctrl.sawtooth_spread_depth == mcrb_pkg::SPREAD_10PCT);
		s_next.ctrl.overtemp_auto_retry =
			~s_next.protection[mcrb_pkg::BIT_RETRY_OFF];
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_reg                              <= '0;
			s_reg.clkout_div                   <= mcrb_pkg::RST_CLKOUT_DIV;
			s_reg.bus_opts                     <= mcrb_pkg::RST_BUS_OPTIONS;
			s_reg.page_sel                     <= mcrb_pkg::RST_PAGE_SELECT;
			s_reg.ramp_ctrl                    <= mcrb_pkg::RST_RAMP_CTRL;
			s_reg.protection                   <= mcrb_pkg::RST_PROTECTION;
			s_reg.ctrl.clkout_divide_by        <= {1'b0, mcrb_pkg::RST_CLKOUT_DIV[6:0]};
			s_reg.ctrl.ramp_cfg_valid          <= 1'b1;
			s_reg.ctrl.overtemp_auto_retry     <=
				~mcrb_pkg::RST_PROTECTION[mcrb_pkg::BIT_RETRY_OFF];
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata       = s_reg.rdata;
	assign rvalid      = s_reg.rvalid;
	assign addr_match  = s_reg.addr_match;
	assign page_select = s_reg.page_sel;
	assign ctrl        = s_reg.ctrl;

	property p_div_power;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> (ctrl.clkout_divider_power == $past(s_next.clkout_div[7]));
	endproperty
	a_div_power: assert property (p_div_power) else $error("divider power wrong");

	property p_div_zero;
		@(posedge ref_clk) disable iff (rst)
		(s_reg.clkout_div[6:0] == 7'h00) |-> (ctrl.clkout_divide_by == 8'h80);
	endproperty
	a_div_zero: assert property (p_div_zero) else $error("ratio zero not 128");

	property p_hang_read;
		@(posedge ref_clk) disable iff (rst)
		(req.rd && req.addr == 8'h7c && s_reg.page_sel == 8'h01 && s_reg.hang_seen)
		|=> (rvalid && rdata[6] == 1'b0);
	endproperty
	a_hang_read: assert property (p_hang_read) else $error("hang not reported");

	property p_hang_clear;
		@(posedge ref_clk) disable iff (rst)
		(req.rd && req.addr == 8'h7c && s_reg.page_sel == 8'h01 && !hang_event)
		|=> !s_reg.hang_seen;
	endproperty
	a_hang_clear: assert property (p_hang_clear) else $error("hang not cleared");

	property p_gcall;
		@(posedge ref_clk) disable iff (rst)
		(bus_addr_valid && bus_addr == 7'h00 && s_reg.bus_opts[5]) |=> addr_match;
	endproperty
	a_gcall: assert property (p_gcall) else $error("general call missed");

	property p_part_id;
		@(posedge ref_clk) disable iff (rst)
		(req.rd && req.addr == 8'h7d && s_reg.page_sel == 8'h01) |=> (rdata == PART_CODE);
	endproperty
	a_part_id: assert property (p_part_id) else $error("part code wrong");

	property p_page;
		@(posedge ref_clk) disable iff (rst)
		(req.wr && !req.rd && req.addr == 8'h00) |=> (page_select == $past(req.wdata));
	endproperty
	a_page: assert property (p_page) else $error("page not written");

	property p_retry;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> (ctrl.overtemp_auto_retry == !$past(s_next.protection[2]));
	endproperty
	a_retry: assert property (p_retry) else $error("retry wrong");

	property p_own_addr;
		@(posedge ref_clk) disable iff (rst)
		(bus_addr_valid && bus_addr == own_addr) |=> addr_match;
	endproperty
	a_own_addr: assert property (p_own_addr) else $error("own address missed");

	// A stray match would make the part answer traffic meant for another device.
	property p_foreign_addr;
		@(posedge ref_clk) disable iff (rst)
		(bus_addr_valid && bus_addr != own_addr &&
		 !(s_reg.bus_opts[mcrb_pkg::BIT_GCALL] && bus_addr == mcrb_pkg::GCALL_ADDR))
		|=> !addr_match;
	endproperty
	a_foreign_addr: assert property (p_foreign_addr) else $error("stray match");

	property p_ramp_freq;
		@(posedge ref_clk) disable iff (rst)
		ctrl.ramp_freq_sel == s_reg.ramp_ctrl[mcrb_pkg::POS_RAMP_FREQ +: 2];
	endproperty
	a_ramp_freq: assert property (p_ramp_freq) else $error("ramp select wrong");

	property p_spread;
		@(posedge ref_clk) disable iff (rst)
		ctrl.sawtooth_spread_depth == s_reg.ramp_ctrl[mcrb_pkg::POS_SPREAD +: 2];
	endproperty
	a_spread: assert property (p_spread) else $error("spread depth wrong");

	property p_cfg_valid;
		@(posedge ref_clk) disable iff (rst)
		(ctrl.ramp_cfg_valid == (s_reg.ramp_ctrl[5:4] < 2'h2)) &&
		(ctrl.spread_cfg_valid == (s_reg.ramp_ctrl[1:0] inside {2'h1, 2'h2}));
	endproperty
	a_cfg_valid: assert property (p_cfg_valid) else $error("reserved code not flagged");

	property p_page_gate;
		@(posedge ref_clk) disable iff (rst)
		(req.wr && !req.rd && req.addr == 8'h76 && s_reg.page_sel != 8'h01)
		|=> $stable(ctrl.clkout_divide_by);
	endproperty
	a_page_gate: assert property (p_page_gate) else $error("write crossed pages");

	property p_read_answer;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> (rvalid == $past(req.rd));
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer mistimed");

endmodule

// ==== core/mcrb_pkg.sv ====
// Package with register map, field layout and reset values of the misc config register bank.
package mcrb_pkg;

	localparam logic [7:0] PAGE_CLK         = 8'h01;
	localparam logic [7:0] PAGE_AMP         = 8'h02;
	localparam logic [7:0] OFS_PAGE_SELECT  = 8'h00;
	localparam logic [7:0] OFS_CLKOUT_DIV   = 8'h76;
	localparam logic [7:0] OFS_BUS_OPTIONS  = 8'h7c;
	localparam logic [7:0] OFS_PART_ID      = 8'h7d;
	localparam logic [7:0] OFS_RAMP_CTRL    = 8'h06;
	localparam logic [7:0] OFS_PROTECTION   = 8'h09;

	localparam logic [7:0] RST_CLKOUT_DIV   = 8'h01;
	localparam logic [7:0] RST_BUS_OPTIONS  = 8'h00;
	localparam logic [7:0] RST_PAGE_SELECT  = 8'h01;
	localparam logic [7:0] RST_RAMP_CTRL    = 8'h00;
	localparam logic [7:0] RST_PROTECTION   = 8'h03;

	localparam int         BIT_DIV_POWER    = 7;
	localparam int         BIT_HANG         = 6;
	localparam int         BIT_GCALL        = 5;
	localparam int         BIT_RETRY_OFF    = 2;
	localparam int         POS_RAMP_FREQ    = 4;
	localparam int         POS_SPREAD       = 0;

	localparam logic [7:0] DIV_RATIO_ZERO   = 8'h80;
	localparam logic [1:0] RAMP_384K        = 2'h0;
	localparam logic [1:0] RAMP_352K8       = 2'h1;
	localparam logic [1:0] SPREAD_5PCT      = 2'h1;
	localparam logic [1:0] SPREAD_10PCT     = 2'h2;
	localparam logic [6:0] GCALL_ADDR       = 7'h00;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mcrb_req_t;

	typedef struct packed {
		logic       clkout_divider_power;
		logic [7:0] clkout_divide_by;
		logic       general_call_accept;
		logic [1:0] ramp_freq_sel;
		logic       ramp_cfg_valid;
		logic [1:0] sawtooth_spread_depth;
		logic       spread_cfg_valid;
		logic       overtemp_auto_retry;
	} mcrb_ctrl_t;

	typedef struct packed {
		logic [7:0] clkout_div;
		logic [7:0] bus_opts;
		logic [7:0] page_sel;
		logic [7:0] ramp_ctrl;
		logic [7:0] protection;
		logic       hang_seen;
		logic [7:0] rdata;
		logic       rvalid;
		logic       addr_match;
		mcrb_ctrl_t ctrl;
	} mcrb_state_t;

endpackage

// ==== dv/mcrb_host.sv ====
// Host model that issues register reads and writes to the bank.
module mcrb_host (
	input  wire logic           ref_clk,
	output mcrb_pkg::mcrb_req_t req,
	input  wire logic [7:0]     rdata,
	input  wire logic           rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req = '0;
	// A released bus shows inverted values so stale data can never look valid.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: (a == 8'h7c) ? (d & 8'hbf) : d};
		@(negedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge ref_clk);
		d = (rvalid === 1'b1) ? rdata : 8'hxx;
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
	endtask
endmodule

// ==== dv/mcrb_tb.sv ====
// Testbench for the misc config register bank.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 ref_clk, rst, hang_event, bus_addr_valid, rvalid, addr_match;
	logic [6:0]           bus_addr, own_addr;
	logic [7:0]           rdata, page_select, v;
	logic [3:0]           fd;
	logic [7:0]           dv [4] = '{8'h80, 8'h85, 8'h7f, 8'h00};
	mcrb_pkg::mcrb_req_t  req;
	mcrb_pkg::mcrb_ctrl_t ctrl;
	int                   err_count, checks;
	mcrb_bank u_dut (.ref_clk(ref_clk), .rst(rst), .req(req), .hang_event(hang_event),
		.bus_addr_valid(bus_addr_valid), .bus_addr(bus_addr), .own_addr(own_addr),
		.rdata(rdata), .rvalid(rvalid), .addr_match(addr_match),
		.page_select(page_select), .ctrl(ctrl));
	mcrb_host u_host (.ref_clk(ref_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		u_host.rd(a, v);
		check(v, exp);
	endtask
	task automatic probe(input logic [6:0] a, input logic exp);
		@(negedge ref_clk);
		bus_addr_valid = 1'b1;
		bus_addr = a;
		@(negedge ref_clk);
		bus_addr_valid = 1'b0;
		bus_addr = ~a;
		check({7'h00, addr_match}, {7'h00, exp});
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// The whole sequence needs well under 1000 cycles, so this bound is generous.
	initial begin
		#50000;
		err_count++;
		close_out();
	end
	initial begin
		rst = 1'b1;
		hang_event = 1'b0;
		bus_addr_valid = 1'b0;
		bus_addr = 7'h00;
		own_addr = 7'h4c;
		repeat (4) @(negedge ref_clk);
		rst = 1'b0;
		check(page_select, 8'h01);
		check({7'h00, ctrl.clkout_divider_power}, 8'h00);
		check({7'h00, ctrl.overtemp_auto_retry}, 8'h01);
		check({7'h00, ctrl.general_call_accept}, 8'h00);
		rchk(8'h76, 8'h01);
		rchk(8'h7c, 8'h40);
		rchk(8'h10, 8'h00);
		$display("test reset done");
		foreach (dv[i]) begin
			u_host.wr(8'h76, dv[i]);
			@(negedge ref_clk);
			check({7'h00, ctrl.clkout_divider_power}, {7'h00, dv[i][7]});
			check(ctrl.clkout_divide_by, (dv[i][6:0] == 7'h00) ? 8'h80 : {1'b0, dv[i][6:0]});
		end
		u_host.wr(8'h7d, 8'hff);
		rchk(8'h7d, 8'h5a);
		$display("test divider and part code done");
		@(negedge ref_clk);
		hang_event = 1'b1;
		@(negedge ref_clk);
		hang_event = 1'b0;
		rchk(8'h7c, 8'h00);
		rchk(8'h7c, 8'h40);
		@(negedge ref_clk);
		hang_event = 1'b1;
		rchk(8'h7c, 8'h00);
		hang_event = 1'b0;
		rchk(8'h7c, 8'h00);
		rchk(8'h7c, 8'h40);
		probe(7'h00, 1'b0);
		probe(7'h4c, 1'b1);
		u_host.wr(8'h7c, 8'h60);
		check({7'h00, ctrl.general_call_accept}, 8'h01);
		rchk(8'h7c, 8'h60);
		probe(7'h00, 1'b1);
		probe(7'h4d, 1'b0);
		$display("test bus options done");
		u_host.wr(8'h00, 8'h02);
		check(page_select, 8'h02);
		u_host.wr(8'h76, 8'h85);
		rchk(8'h76, 8'h00);
		check(ctrl.clkout_divide_by, 8'h80);
		rchk(8'h09, 8'h03);
		for (int i = 0; i < 16; i++) begin
			fd = i[3:0];
			u_host.wr(8'h06, {2'b00, fd[3:2], 2'b00, fd[1:0]});
			@(negedge ref_clk);
			check({2'b00, ctrl.ramp_freq_sel, ctrl.ramp_cfg_valid, ctrl.spread_cfg_valid,
				ctrl.sawtooth_spread_depth}, {2'b00, fd[3:2], fd[3:2] < 2'h2,
				fd[1:0] == 2'h1 || fd[1:0] == 2'h2, fd[1:0]});
			rchk(8'h06, {2'b00, fd[3:2], 2'b00, fd[1:0]});
		end
		u_host.wr(8'h09, 8'h07);
		@(negedge ref_clk);
		check({7'h00, ctrl.overtemp_auto_retry}, 8'h00);
		u_host.wr(8'h09, 8'h03);
		@(negedge ref_clk);
		check({7'h00, ctrl.overtemp_auto_retry}, 8'h01);
		$display("test page two done");
		@(negedge ref_clk);
		hang_event = 1'b1;
		@(negedge ref_clk);
		hang_event = 1'b0;
		rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		check(page_select, 8'h01);
		check(ctrl.clkout_divide_by, 8'h01);
		rchk(8'h7c, 8'h40);
		rchk(8'h76, 8'h01);
		$display("test second reset done");
		close_out();
	end
endmodule
